// *** inc/fbr_defs.svh ***
`ifndef FBR_DEFS_SVH
`define FBR_DEFS_SVH
// ****************************************
// Link widths
// ****************************************
`define FBR_DQ_W         16
`define FBR_PIN_N        6
// ****************************************
// Configuration register layout
// ****************************************
`define FBR_CR_RESET     16'hafc8
`define FBR_CR_MODE_BIT  15
`define FBR_CR_LAT_HI    13
`define FBR_CR_LAT_LO    11
`define FBR_CR_POL_BIT   10
`define FBR_CR_TIM_BIT   8
`define FBR_LAT_EDGE_OFS 4'h2
// ****************************************
// Burst geometry and command codes
// ****************************************
`define FBR_LINE_BITS    7
`define FBR_CMD_RESET    16'h00f0
`define FBR_CMD_SETCFG   16'h0060
`define FBR_CMD_PROG     16'h00a0
`define FBR_STATUS_WORD  16'h0080
// ****************************************
// Timing
// ****************************************
`define FBR_MCLK_MHZ     200
`define FBR_TOE_NS       15
// ****************************************
// Controller register offsets and fields
// ****************************************
`define FBR_REG_CTRL     4'h0
`define FBR_REG_ADDR     4'h1
`define FBR_REG_WDATA    4'h2
`define FBR_REG_LEN      4'h3
`define FBR_REG_STATUS   4'h4
`define FBR_REG_RDATA    4'h5
`define FBR_REG_COUNT    4'h6
`define FBR_CTRL_POL_BIT 2
`define FBR_CTRL_RST_BIT 3
`endif

// *** inc/fbr_pkg.sv ***
`default_nettype none
package fbr_pkg;
  typedef enum logic [1:0] {
    fbr_op_aread, fbr_op_write, fbr_op_burst, fbr_op_stop
  } fbr_op_e;
  typedef enum logic [1:0] {
    cmd_read, cmd_cfg, cmd_prog, cmd_lost
  } fbr_cmd_e;
  typedef enum logic [1:0] {
    dev_idle, dev_lat, dev_stream, dev_status
  } fbr_dev_e;
  typedef enum logic [2:0] {
    h_idle, h_avd, h_oe, h_wdata, h_burst, h_end
  } fbr_host_e;
endpackage
`default_nettype wire

// *** inc/fbr_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbr_defs.svh"
interface fbr_link_if;
  logic                 ce_n;
  logic                 oe_n;
  logic                 we_n;
  logic                 reset_n;
  logic                 address_valid_n;
  logic                 burst_clk;
  logic [`FBR_DQ_W-1:0] host_dq_o;
  logic                 host_dq_oe;
  logic [`FBR_DQ_W-1:0] dev_dq_o;
  logic                 dev_dq_oe;
  logic                 rdy;
  logic [`FBR_DQ_W-1:0] muxed_addr_data_bus;
  // Resolved level of the shared lines; undriven reads as zero
  assign muxed_addr_data_bus = dev_dq_oe ? dev_dq_o :
                               (host_dq_oe ? host_dq_o : '0);
  modport dev (
    input  ce_n, oe_n, we_n, reset_n, address_valid_n, burst_clk,
    input  muxed_addr_data_bus,
    output dev_dq_o, dev_dq_oe, rdy
  );
  modport host (
    output ce_n, oe_n, we_n, reset_n, address_valid_n, burst_clk,
    output host_dq_o, host_dq_oe,
    input  muxed_addr_data_bus, rdy
  );
endinterface
`default_nettype wire

// *** core/fbr_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbr_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         mclk,   // System clock
  input  wire logic         rst,    // Async reset
  input  wire logic         clk_en, // Freeze when low
  input  wire logic [W-1:0] d,      // Foreign-domain input
  output logic      [W-1:0] q       // Synchronised output
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= RST_VAL;
      q    <= RST_VAL;
    end else if (clk_en) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// *** core/fbr_dev.sv ***
// Overview of operation
// - Writes captured in command latches drive state.
// - Bad command sequence locks until reset command.
// - Reset returns to asynchronous array read mode.
// - Host presents address with strobe, select low.
// - Address latched on strobe rising edge.
// - Data driven output-enable access time after enable; code skips the wait in synchronous mode.
// - Host must configure synchronous mode before bursts.
// - First word after programmed initial latency edges.
// - Each later edge presents next word, increments.
// - Misaligned start inserts offset waits at alignment.
// - Line crossing inserts one extra wait.
// - Latency configured to suit clock frequency.
// - Ready output marks available burst words.
// - Continuous burst wraps to lowest address.
// - Select high or reset pin ends burst.
// - New strobe aborts burst, restarts there.
// - Busy bank crossing returns status, ignores clock.
// - Latency codes pick 5th, 6th, 7th edge.
// - Mode bit zero synchronous, one asynchronous.
// - Polarity bit zero low, one high ready.
// - Timing bit zero early, one with data.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fbr_defs.svh"
module fbr_dev #(
  parameter int AW = 8
) (
  input  wire logic                 mclk,           // System clock
  input  wire logic                 rst,            // Async reset
  input  wire logic                 clk_en,         // Freeze when low
  fbr_link_if.dev                   fl,             // Flash pins
  input  wire logic                 bank_busy,      // Next line busy
  input  wire logic                 boundary_ws_en, // High-speed clock
  output logic      [`FBR_DQ_W-1:0] cfg,            // Config register
  output logic                      cmd_locked      // Unknown state
);
  localparam int TOE_CYC =
    (`FBR_TOE_NS * `FBR_MCLK_MHZ + 999) / 1000;
  localparam int SW = `FBR_PIN_N + `FBR_DQ_W;

  // ****************************************
  // Pin synchronisation and edges
  // ****************************************
  logic [SW-1:0]        pin_s;
  logic                 s_rst_n;
  logic                 s_ce_n;
  logic                 s_oe_n;
  logic                 s_we_n;
  logic                 s_avd_n;
  logic                 s_clk;
  logic [`FBR_DQ_W-1:0] s_bus;
  logic                 p_avd_n;
  logic                 p_we_n;
  logic                 p_clk;
  logic                 avd_rise;
  logic                 we_rise;
  logic                 clk_rise;
  logic                 hw_reset;

  fbr_sync #(
    .W       (SW),
    .RST_VAL ({6'h3e, 16'h0000})
  ) fbr_sync_inst (
    .mclk   (mclk),
    .rst    (rst),
    .clk_en (clk_en),
    .d      ({fl.reset_n, fl.ce_n, fl.oe_n, fl.we_n,
              fl.address_valid_n, fl.burst_clk,
              fl.muxed_addr_data_bus}),
    .q      (pin_s)
  );

  assign {s_rst_n, s_ce_n, s_oe_n, s_we_n, s_avd_n, s_clk, s_bus} =
    pin_s;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      p_avd_n <= 1'b1;
      p_we_n  <= 1'b1;
      p_clk   <= 1'b0;
    end else if (clk_en) begin
      p_avd_n <= s_avd_n;
      p_we_n  <= s_we_n;
      p_clk   <= s_clk;
    end
  end

  assign hw_reset = ~s_rst_n;
  assign avd_rise = s_avd_n & ~p_avd_n & ~s_ce_n;
  assign we_rise  = s_we_n & ~p_we_n & ~s_ce_n;
  assign clk_rise = s_clk & ~p_clk & ~s_ce_n;

  // ****************************************
  // Command latches and configuration
  // ****************************************
  logic [AW-1:0]        addr;
  logic                 cmd_vld;
  logic [AW-1:0]        cmd_addr;
  logic [`FBR_DQ_W-1:0] cmd_data;
  fbr_pkg::fbr_cmd_e    cmd_st;
  logic [`FBR_DQ_W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr <= '0;
    end else if (clk_en && avd_rise) begin
      addr <= s_bus[AW-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_vld  <= 1'b0;
      cmd_addr <= '0;
      cmd_data <= '0;
    end else if (clk_en) begin
      cmd_vld <= we_rise;
      if (we_rise) begin
        cmd_addr <= addr;
        cmd_data <= s_bus;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cmd_st <= fbr_pkg::cmd_read;
      cfg    <= `FBR_CR_RESET;
    end else if (clk_en) begin
      if (hw_reset) begin
        cmd_st <= fbr_pkg::cmd_read;
        cfg    <= `FBR_CR_RESET;
      end else if (cmd_vld) begin
        case (cmd_st)
          fbr_pkg::cmd_read: begin
            if (cmd_data == `FBR_CMD_SETCFG) begin
              cmd_st <= fbr_pkg::cmd_cfg;
            end else if (cmd_data == `FBR_CMD_PROG) begin
              cmd_st <= fbr_pkg::cmd_prog;
            end else if (cmd_data != `FBR_CMD_RESET) begin
              cmd_st <= fbr_pkg::cmd_lost;
            end
          end
          fbr_pkg::cmd_cfg: begin
            cfg    <= cmd_data;
            cmd_st <= fbr_pkg::cmd_read;
          end
          fbr_pkg::cmd_prog: begin
            cmd_st <= fbr_pkg::cmd_read;
          end
          default: begin
            if (cmd_data == `FBR_CMD_RESET) begin
              cmd_st <= fbr_pkg::cmd_read;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (clk_en && cmd_vld && cmd_st == fbr_pkg::cmd_prog) begin
      mem[cmd_addr] <= cmd_data;
    end
  end

  assign cmd_locked = (cmd_st == fbr_pkg::cmd_lost);

  // ****************************************
  // Burst sequencer
  // ****************************************
  logic               sync_mode;
  logic [3:0]         first_edge;
  fbr_pkg::fbr_dev_e  rd_st;
  logic [AW-1:0]      baddr;
  logic [AW-1:0]      nxt;
  logic [3:0]         edge_cnt;
  logic [2:0]         wait_cnt;
  logic [1:0]         start_ofs;
  logic               first_grp;
  logic               data_now;

  assign sync_mode  = ~cfg[`FBR_CR_MODE_BIT];
  assign first_edge = {1'b0, cfg[`FBR_CR_LAT_HI:`FBR_CR_LAT_LO]}
                      + `FBR_LAT_EDGE_OFS;
  assign nxt        = baddr + 1'b1;

  // Wait states owed before word a is presented
  function automatic logic [2:0] waits_before(
    input logic [AW-1:0] a,
    input logic          grp,
    input logic [1:0]    ofs,
    input logic          bnd
  );
    logic [2:0] w;
    w = 3'h0;
    if (grp && a[1:0] == 2'h0) begin
      w = {1'b0, ofs};
    end
    if (bnd && a[`FBR_LINE_BITS-1:0] == '0) begin
      w = w + 3'h1;
    end
    return w;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_st     <= fbr_pkg::dev_idle;
      baddr     <= '0;
      edge_cnt  <= 4'h0;
      wait_cnt  <= 3'h0;
      start_ofs <= 2'h0;
      first_grp <= 1'b0;
      data_now  <= 1'b0;
    end else if (clk_en) begin
      if (hw_reset || s_ce_n) begin
        rd_st    <= fbr_pkg::dev_idle;
        data_now <= 1'b0;
      end else if (avd_rise) begin
        baddr     <= s_bus[AW-1:0];
        edge_cnt  <= 4'h0;
        wait_cnt  <= 3'h0;
        start_ofs <= s_bus[1:0];
        first_grp <= (s_bus[1:0] != 2'h0);
        data_now  <= 1'b0;
        rd_st     <= (sync_mode && cmd_st == fbr_pkg::cmd_read) ?
                     fbr_pkg::dev_lat : fbr_pkg::dev_idle;
      end else if (clk_rise) begin
        case (rd_st)
          fbr_pkg::dev_lat: begin
            edge_cnt <= edge_cnt + 4'h1;
            if (edge_cnt + 4'h1 == first_edge) begin
              rd_st    <= fbr_pkg::dev_stream;
              data_now <= 1'b1;
              wait_cnt <= waits_before(nxt, first_grp, start_ofs,
                                       boundary_ws_en);
            end
          end
          fbr_pkg::dev_stream: begin
            if (wait_cnt != 3'h0) begin
              wait_cnt <= wait_cnt - 3'h1;
              data_now <= 1'b0;
            end else if (nxt[`FBR_LINE_BITS-1:0] == '0 && bank_busy) begin
              rd_st    <= fbr_pkg::dev_status;
              data_now <= 1'b0;
            end else begin
              baddr    <= nxt;
              data_now <= 1'b1;
              wait_cnt <= waits_before(nxt + 1'b1, first_grp, start_ofs,
                                       boundary_ws_en);
              if (nxt[1:0] == 2'h0) begin
                first_grp <= 1'b0;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************
  // Data, enable and ready outputs
  // ****************************************
  logic [3:0] toe_cnt;
  logic       rdy_raw;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      toe_cnt      <= 4'h0;
      fl.dev_dq_oe <= 1'b0;
    end else if (clk_en) begin
      if (s_ce_n || s_oe_n || hw_reset) begin
        toe_cnt      <= 4'h0;
        fl.dev_dq_oe <= 1'b0;
      end else if (sync_mode || toe_cnt == 4'(TOE_CYC - 1)) begin
        fl.dev_dq_oe <= 1'b1;
      end else begin
        toe_cnt <= toe_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl.dev_dq_o <= '0;
    end else if (clk_en) begin
      if (rd_st == fbr_pkg::dev_status) begin
        fl.dev_dq_o <= `FBR_STATUS_WORD;
      end else if (rd_st == fbr_pkg::dev_idle) begin
        fl.dev_dq_o <= mem[addr];
      end else begin
        fl.dev_dq_o <= mem[baddr];
      end
    end
  end

  always_comb begin
    rdy_raw = 1'b1;
    if (rd_st == fbr_pkg::dev_status) begin
      rdy_raw = 1'b0;
    end else if (rd_st == fbr_pkg::dev_lat) begin
      rdy_raw = ~cfg[`FBR_CR_TIM_BIT] &&
                (edge_cnt + 4'h1 == first_edge);
    end else if (rd_st == fbr_pkg::dev_stream) begin
      rdy_raw = cfg[`FBR_CR_TIM_BIT] ? data_now
                                     : (wait_cnt == 3'h0);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl.rdy <= 1'b1;
    end else if (clk_en) begin
      fl.rdy <= cfg[`FBR_CR_POL_BIT] ? rdy_raw : ~rdy_raw;
    end
  end
endmodule
`default_nettype wire

// *** core/fbr_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbr_defs.svh"
module fbr_host #(
  parameter int CLK_HALF = 5,
  parameter int PH       = 8,
  parameter int RD_WAIT  = 16
) (
  input  wire logic                 mclk,      // System clock
  input  wire logic                 rst,       // Async reset
  input  wire logic                 clk_en,    // Freeze when low
  input  wire logic [3:0]           reg_addr,  // Register index
  input  wire logic [`FBR_DQ_W-1:0] reg_wdata, // Write data
  input  wire logic                 reg_wr,    // Write strobe
  input  wire logic                 reg_rd,    // Read strobe
  output logic      [`FBR_DQ_W-1:0] reg_rdata, // Read data
  fbr_link_if.host                  fl         // Flash pins
);
  // ****************************************
  // Software registers
  // ****************************************
  fbr_pkg::fbr_host_e   st;
  logic [`FBR_DQ_W-1:0] addr_r;
  logic [`FBR_DQ_W-1:0] wdata_r;
  logic [`FBR_DQ_W-1:0] len_r;
  logic [`FBR_DQ_W-1:0] rdata_r;
  logic [`FBR_DQ_W-1:0] count_r;
  logic                 pol_r;
  logic                 pin_rst_r;
  logic                 go;
  fbr_pkg::fbr_op_e     op;
  fbr_pkg::fbr_op_e     cur_op;

  assign go = reg_wr && reg_addr == `FBR_REG_CTRL;
  assign op = fbr_pkg::fbr_op_e'(reg_wdata[1:0]);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      addr_r    <= '0;
      wdata_r   <= '0;
      len_r     <= '0;
      pol_r     <= 1'b1;
      pin_rst_r <= 1'b0;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `FBR_REG_CTRL) begin
        pol_r     <= reg_wdata[`FBR_CTRL_POL_BIT];
        pin_rst_r <= reg_wdata[`FBR_CTRL_RST_BIT];
      end else if (reg_addr == `FBR_REG_ADDR) begin
        addr_r <= reg_wdata;
      end else if (reg_addr == `FBR_REG_WDATA) begin
        wdata_r <= reg_wdata;
      end else if (reg_addr == `FBR_REG_LEN) begin
        len_r <= reg_wdata;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      if (!reg_rd) begin
        reg_rdata <= '0;
      end else if (reg_addr == `FBR_REG_STATUS) begin
        reg_rdata <= {15'h0000, st != fbr_pkg::h_idle};
      end else if (reg_addr == `FBR_REG_RDATA) begin
        reg_rdata <= rdata_r;
      end else if (reg_addr == `FBR_REG_COUNT) begin
        reg_rdata <= count_r;
      end else begin
        reg_rdata <= '0;
      end
    end
  end

  // ****************************************
  // Link sequencer
  // ****************************************
  logic [`FBR_DQ_W:0] in_s;
  logic               rdy_act;
  logic [7:0]         tmr;
  logic [7:0]         div;
  logic               fall;

  fbr_sync #(
    .W       (`FBR_DQ_W + 1),
    .RST_VAL ('0)
  ) fbr_sync_inst (
    .mclk   (mclk),
    .rst    (rst),
    .clk_en (clk_en),
    .d      ({fl.rdy, fl.muxed_addr_data_bus}),
    .q      (in_s)
  );

  assign rdy_act = (in_s[`FBR_DQ_W] == pol_r);
  assign fall    = fl.burst_clk && div == 8'(CLK_HALF - 1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div          <= 8'h00;
      fl.burst_clk <= 1'b0;
    end else if (clk_en) begin
      if (st != fbr_pkg::h_burst) begin
        div          <= 8'h00;
        fl.burst_clk <= 1'b0;
      end else if (div == 8'(CLK_HALF - 1)) begin
        div          <= 8'h00;
        fl.burst_clk <= ~fl.burst_clk;
      end else begin
        div <= div + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st      <= fbr_pkg::h_idle;
      cur_op  <= fbr_pkg::fbr_op_aread;
      tmr     <= 8'h00;
      rdata_r <= '0;
      count_r <= '0;
    end else if (clk_en) begin
      tmr <= tmr + 8'h01;
      case (st)
        fbr_pkg::h_idle: begin
          tmr <= 8'h00;
          if (go && op != fbr_pkg::fbr_op_stop) begin
            cur_op  <= op;
            count_r <= '0;
            st      <= fbr_pkg::h_avd;
          end
        end
        fbr_pkg::h_avd: begin
          if (tmr == 8'(PH - 1)) begin
            tmr <= 8'h00;
            if (cur_op == fbr_pkg::fbr_op_write) begin
              st <= fbr_pkg::h_wdata;
            end else if (cur_op == fbr_pkg::fbr_op_burst) begin
              st <= fbr_pkg::h_burst;
            end else begin
              st <= fbr_pkg::h_oe;
            end
          end
        end
        fbr_pkg::h_oe: begin
          if (tmr == 8'(RD_WAIT - 1)) begin
            rdata_r <= in_s[`FBR_DQ_W-1:0];
            count_r <= 16'h0001;
            tmr     <= 8'h00;
            st      <= fbr_pkg::h_end;
          end
        end
        fbr_pkg::h_wdata: begin
          if (tmr == 8'(PH - 1)) begin
            tmr <= 8'h00;
            st  <= fbr_pkg::h_end;
          end
        end
        fbr_pkg::h_burst: begin
          if (go && op == fbr_pkg::fbr_op_burst) begin
            tmr     <= 8'h00;
            count_r <= '0;
            st      <= fbr_pkg::h_avd;
          end else if (go && op == fbr_pkg::fbr_op_stop) begin
            tmr <= 8'h00;
            st  <= fbr_pkg::h_end;
          end else if (fall && rdy_act) begin
            rdata_r <= in_s[`FBR_DQ_W-1:0];
            count_r <= count_r + 16'h0001;
            if (count_r + 16'h0001 == len_r) begin
              tmr <= 8'h00;
              st  <= fbr_pkg::h_end;
            end
          end
        end
        default: begin
          if (tmr == 8'(PH - 1)) begin
            st <= fbr_pkg::h_idle;
          end
        end
      endcase
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fl.ce_n            <= 1'b1;
      fl.oe_n            <= 1'b1;
      fl.we_n            <= 1'b1;
      fl.reset_n         <= 1'b1;
      fl.address_valid_n <= 1'b1;
      fl.host_dq_o       <= '0;
      fl.host_dq_oe      <= 1'b0;
    end else if (clk_en) begin
      fl.reset_n         <= ~pin_rst_r;
      fl.ce_n            <= (st == fbr_pkg::h_idle ||
                             st == fbr_pkg::h_end);
      fl.address_valid_n <= !(st == fbr_pkg::h_avd &&
                              tmr >= 8'h03 &&
                              tmr < 8'(PH - 2));
      fl.we_n            <= !(st == fbr_pkg::h_wdata &&
                              tmr < 8'(PH / 2));
      fl.oe_n            <= !(st == fbr_pkg::h_oe ||
                              st == fbr_pkg::h_burst);
      // Bus drive waits for the device to release it after a restart
      fl.host_dq_oe      <= (st == fbr_pkg::h_avd && tmr >= 8'h03) ||
                            (st == fbr_pkg::h_wdata);
      fl.host_dq_o       <= (st == fbr_pkg::h_wdata) ? wdata_r : addr_r;
    end
  end
endmodule
`default_nettype wire

// *** test/fbr_link_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module fbr_link_sva (
  input wire logic mclk,            // Clock
  input wire logic rst,             // Reset
  input wire logic ce_n,            // Select
  input wire logic oe_n,            // Output enable
  input wire logic we_n,            // Write enable
  input wire logic reset_n,         // Reset pin
  input wire logic address_valid_n, // Address strobe
  input wire logic host_dq_oe,      // Host drive
  input wire logic dev_dq_oe,       // Device drive
  input wire logic rdy              // Ready
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  hiz_idle_a: assert property (ce_n [*5] |-> !dev_dq_oe)
    else $error("bus driven while deselected");
  no_clash_a: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drive the bus");
  oe_order_a: assert property ($fell(oe_n) |-> address_valid_n && we_n)
    else $error("output enable before strobe released");
  avd_sel_a: assert property ($rose(address_valid_n) |-> !ce_n)
    else $error("address latched while deselected");
  oe_access_a: assert property ($fell(oe_n) |-> ##[2:8] dev_dq_oe)
    else $error("no data after output enable");
  drv_cause_a: assert property ($rose(dev_dq_oe) |-> !oe_n && !ce_n)
    else $error("device drives without enable");
  pin_rdy_a: assert property (!reset_n [*5] |-> rdy && !dev_dq_oe)
    else $error("reset pin left burst running");
  we_cmd_a: assert property ($fell(we_n) |-> !ce_n && oe_n)
    else $error("command write without select");
  cover property ($rose(dev_dq_oe));
  cover property (!reset_n [*5]);
  cover property ($fell(we_n));
endmodule
`default_nettype wire

// *** test/test_flash_async_burst_read_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "fbr_defs.svh"
module test_flash_async_burst_read_port;
  typedef struct packed {
    logic [15:0] cfg;
    logic        pol;
    logic [1:0]  op;
    logic [7:0]  a;
    logic [7:0]  n;
  } fbr_row_s;
  logic        mclk;
  logic        rst       = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] cfg;
  logic        cmd_locked;
  logic        bank_busy = 1'b0;
  logic        bnd_ws    = 1'b1;
  logic        pol       = 1'b1;
  logic [15:0] d;
  int          n_errors  = 0;
  int          tests_run = 0;
  logic [7:0]  pa[12] = '{8'hfe, 8'hff, 8'h00, 8'h01, 8'h7d, 8'h7e,
                          8'h7f, 8'h80, 8'h81, 8'h40, 8'h41, 8'h42};
  fbr_row_s    rows[4] = '{'{16'hafc8, 1'b1, 2'h0, 8'h41, 8'h01},
                           '{16'h1fc8, 1'b1, 2'h2, 8'hfe, 8'h04},
                           '{16'h27c8, 1'b1, 2'h2, 8'h7d, 8'h05},
                           '{16'h2bc8, 1'b0, 2'h2, 8'h40, 8'h03}};
  fbr_link_if fbr_link_if_inst ();
  fbr_dev fbr_dev_inst (.mclk(mclk), .rst(rst), .clk_en(1'b1),
    .fl(fbr_link_if_inst.dev), .bank_busy(bank_busy),
    .boundary_ws_en(bnd_ws), .cfg(cfg), .cmd_locked(cmd_locked));
  fbr_host fbr_host_inst (.mclk(mclk), .rst(rst), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl(fbr_link_if_inst.host));
  fbr_link_sva fbr_link_sva_inst (.mclk(mclk), .rst(rst),
    .ce_n(fbr_link_if_inst.ce_n), .oe_n(fbr_link_if_inst.oe_n),
    .we_n(fbr_link_if_inst.we_n), .reset_n(fbr_link_if_inst.reset_n),
    .address_valid_n(fbr_link_if_inst.address_valid_n),
    .host_dq_oe(fbr_link_if_inst.host_dq_oe),
    .dev_dq_oe(fbr_link_if_inst.dev_dq_oe), .rdy(fbr_link_if_inst.rdy));
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  function automatic logic [15:0] dat(input logic [7:0] a);
    return {8'h5a, a};
  endfunction
  task automatic report_and_stop;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic go(input logic [1:0] op);
    logic [15:0] s;
    wr(`FBR_REG_CTRL, {13'h0, pol, op});
    for (int k = 0; k < 400; k++) begin
      rd(`FBR_REG_STATUS, s);
      if (s[0] === 1'b0) return;
    end
    n_errors++;
    report_and_stop;
  endtask
  task automatic cmd(input logic [7:0] a, input logic [15:0] v);
    wr(`FBR_REG_ADDR, {8'h00, a});
    wr(`FBR_REG_WDATA, v);
    go(2'h1);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    chk(cfg, `FBR_CR_RESET);
    rd(4'hf, d);
    chk(d, 16'h0000);
    foreach (pa[i]) begin
      cmd(8'h00, `FBR_CMD_PROG);
      cmd(pa[i], dat(pa[i]));
    end
    foreach (rows[i]) begin
      pol = rows[i].pol;
      cmd(8'h00, `FBR_CMD_SETCFG);
      cmd(8'h00, rows[i].cfg);
      chk(cfg, rows[i].cfg);
      wr(`FBR_REG_ADDR, {8'h00, rows[i].a});
      wr(`FBR_REG_LEN, {8'h00, rows[i].n});
      go(rows[i].op);
      rd(`FBR_REG_RDATA, d);
      chk(d, dat(8'(rows[i].a + rows[i].n - 8'h01)));
      rd(`FBR_REG_COUNT, d);
      chk(d, {8'h00, rows[i].n});
    end
    bank_busy <= 1'b1;
    wr(`FBR_REG_ADDR, 16'h007e);
    wr(`FBR_REG_LEN, 16'h0004);
    wr(`FBR_REG_CTRL, {13'h0, pol, 2'h2});
    repeat (200) @(posedge mclk);
    d = fbr_link_if_inst.muxed_addr_data_bus;
    chk(d, `FBR_STATUS_WORD);
    rd(`FBR_REG_COUNT, d);
    chk(d, 16'h0002);
    bank_busy <= 1'b0;
    wr(`FBR_REG_ADDR, 16'h0040);
    wr(`FBR_REG_LEN, 16'h0002);
    go(2'h2);
    rd(`FBR_REG_RDATA, d);
    chk(d, dat(8'h41));
    rd(`FBR_REG_COUNT, d);
    chk(d, 16'h0002);
    cmd(8'h00, 16'h0055);
    chk({15'h0, cmd_locked}, 16'h0001);
    cmd(8'h00, `FBR_CMD_RESET);
    chk({15'h0, cmd_locked}, 16'h0000);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    chk(cfg, `FBR_CR_RESET);
    cmd(8'h00, `FBR_CMD_SETCFG);
    cmd(8'h00, 16'h2bc8);
    wr(`FBR_REG_CTRL, 16'h000b);
    repeat (8) @(posedge mclk);
    wr(`FBR_REG_CTRL, 16'h0007);
    repeat (4) @(posedge mclk);
    chk(cfg, `FBR_CR_RESET);
    report_and_stop;
  end
endmodule
`default_nettype wire
